/* File: rtl/csc_chan_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface csc_chan_if;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] ctrl;
  logic        evt;

  modport hub  (output wr, output wdata, input ctrl, input evt);
  modport chan (input wr, input wdata, output ctrl, output evt);
endinterface
`default_nettype wire

/* File: rtl/csc_channel.sv */
`timescale 1ns/100ps
`default_nettype none
module csc_channel (
  input  wire logic       clk,
  input  wire logic       rst,
  csc_chan_if.chan        bus,
  input  wire logic       cmp_raw,
  output logic            ref_sel,
  output logic [1:0]      ch_sel
);
  logic sync1;
  logic sync2;
  logic last;
  logic evt_flag;
  logic edge_seen;

  // Comparator output is asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last  <= 1'b0;
    end else begin
      sync1 <= cmp_raw;
      sync2 <= sync1;
      last  <= sync2;
    end
  end

  assign edge_seen = sync2 ^ last;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_sel <= csc_pkg::RST_REF;
      ch_sel  <= csc_pkg::RST_CH;
    end else if (bus.wr) begin
      ref_sel <= bus.wdata[csc_pkg::CTRL_REF];
      ch_sel  <= bus.wdata[csc_pkg::CTRL_CH_MSB:csc_pkg::CTRL_CH_LSB];
    end
  end

  // Event flag: set on any output change, cleared by writing zero; set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_flag <= 1'b0;
      bus.evt  <= 1'b0;
    end else begin
      bus.evt <= edge_seen;
      if (edge_seen) begin
        evt_flag <= 1'b1;
      end else if (bus.wr && !bus.wdata[csc_pkg::CTRL_EVT]) begin
        evt_flag <= 1'b0;
      end
    end
  end

  always_comb begin
    bus.ctrl = 16'h0000;
    bus.ctrl[csc_pkg::CTRL_CH_MSB:csc_pkg::CTRL_CH_LSB] = ch_sel;
    bus.ctrl[csc_pkg::CTRL_REF] = ref_sel;
    bus.ctrl[csc_pkg::CTRL_OUT] = sync2;
    bus.ctrl[csc_pkg::CTRL_EVT] = evt_flag;
  end
endmodule
`default_nettype wire

/* File: rtl/csc_irq.sv */
`timescale 1ns/100ps
`default_nettype none
module csc_irq (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] set,
  input  wire logic       wr_flags,
  input  wire logic       wr_mask,
  input  wire logic [2:0] wdata,
  output logic      [2:0] flags,
  output logic      [2:0] mask,
  output logic            irq
);
  logic [2:0] clr;

  assign clr = wr_flags ? wdata : 3'h0;

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= 3'h0;
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask <= csc_pkg::RST_MASK;
    end else if (wr_mask) begin
      mask <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & mask);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/csc_pkg.sv */
package csc_pkg;

  localparam int NUM_CMP = 3;

  // Word addresses on the register bus
  localparam logic [3:0] ADDR_CTRL1     = 4'h0;
  localparam logic [3:0] ADDR_CTRL2     = 4'h1;
  localparam logic [3:0] ADDR_CTRL3     = 4'h2;
  localparam logic [3:0] ADDR_STATUS    = 4'h3;
  localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'h5;

  // Channel control register fields
  localparam int CTRL_CH_LSB = 0;
  localparam int CTRL_CH_MSB = 1;
  localparam int CTRL_REF    = 4;
  localparam int CTRL_OUT    = 8;
  localparam int CTRL_EVT    = 9;

  // Shared status register fields
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_EVT_LSB = 8;
  localparam int STAT_IDLE    = 15;

  // Inverting input selections
  localparam logic [1:0] CH_PIN_B       = 2'h0;
  localparam logic [1:0] CH_PIN_C       = 2'h1;
  localparam logic [1:0] CH_PIN_D       = 2'h2;
  localparam logic [1:0] CH_HALF_BANDGAP = 2'h3;

  localparam logic [1:0]  RST_CH     = 2'h0;
  localparam logic        RST_REF    = 1'b0;
  localparam logic        RST_IDLE   = 1'b0;
  localparam logic [2:0]  RST_MASK   = 3'h0;
  localparam logic [15:0] RST_STATUS = 16'h0000;

endpackage

/* File: rtl/csc_status_control.sv */
// Summary of operation
// - Reference select bit 4 routes the non-inverting input to the internal reference when one, to input pin A when zero.
// - Channel select bits 1-0 route the inverting input: 11 half bandgap, 10 pin D, 01 pin C, 00 pin B.
// - Unimplemented bits of the channel control and shared status registers read as zero.
// - With idle stop set, interrupt requests are suppressed in Idle mode while comparisons continue.
// - With idle stop clear, the module works fully in Idle mode, interrupts included.
// - Status bit 10 mirrors comparator 3's event flag at control bit 9.
// - Status bit 9 mirrors comparator 2's event flag at control bit 9.
// - Status bit 8 mirrors comparator 1's event flag at control bit 9.
// - Status bit 2 mirrors comparator 3's output level at control bit 8.
// - Status bit 1 mirrors comparator 2's output level at control bit 8.
// - Status bit 0 mirrors comparator 1's output level at control bit 8.
// - After reset every implemented status bit reads zero.
`timescale 1ns/100ps
`default_nettype none
module csc_status_control (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        idle_mode,
  input  wire logic [2:0]  cmp_out_raw,
  output logic      [2:0]  pos_ref_sel,
  output logic      [5:0]  neg_chan_sel,
  output logic             irq
);
  csc_chan_if chan [csc_pkg::NUM_CMP] ();

  logic [15:0] ctrl_rd [csc_pkg::NUM_CMP];
  logic [2:0]  evt_pulse;
  logic [2:0]  evt_level;
  logic [2:0]  out_level;
  logic        idle_stop;
  logic [15:0] status_rd;
  logic        wr_go;
  logic        rd_go;
  logic [2:0]  irq_flags;
  logic [2:0]  irq_mask;
  logic [2:0]  irq_set;
  logic [15:0] wr_val;

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // Answer one cycle after the request is seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  assign wr_go = avs_write && !avs_waitrequest;
  assign rd_go = avs_read && avs_waitrequest;

  genvar g;
  generate
    for (g = 0; g < csc_pkg::NUM_CMP; g++) begin : g_cmp
      logic [1:0] ch;
      assign ctrl_rd[g]    = chan[g].ctrl;
      assign evt_pulse[g]  = chan[g].evt;
      assign evt_level[g]  = chan[g].ctrl[csc_pkg::CTRL_EVT];
      assign out_level[g]  = chan[g].ctrl[csc_pkg::CTRL_OUT];
      assign chan[g].wr    = wr_go && (avs_address == 4'(g));
      assign chan[g].wdata = merge16(chan[g].ctrl, avs_writedata, avs_byteenable);
      csc_channel u_chan (
        .clk     (clk),
        .rst     (rst),
        .bus     (chan[g]),
        .cmp_raw (cmp_out_raw[g]),
        .ref_sel (pos_ref_sel[g]),
        .ch_sel  (ch)
      );
      assign neg_chan_sel[2*g+1:2*g] = ch;
    end
  endgenerate

  assign wr_val = merge16(status_rd, avs_writedata, avs_byteenable);

  // Only the idle stop bit is writable in the shared status register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_stop <= csc_pkg::RST_IDLE;
    end else if (wr_go && avs_address == csc_pkg::ADDR_STATUS) begin
      idle_stop <= wr_val[csc_pkg::STAT_IDLE];
    end
  end

  always_comb begin
    status_rd = csc_pkg::RST_STATUS;
    status_rd[csc_pkg::STAT_IDLE] = idle_stop;
    status_rd[csc_pkg::STAT_EVT_LSB+2] = evt_level[2];
    status_rd[csc_pkg::STAT_EVT_LSB+1] = evt_level[1];
    status_rd[csc_pkg::STAT_EVT_LSB]   = evt_level[0];
    status_rd[csc_pkg::STAT_OUT_LSB+2] = out_level[2];
    status_rd[csc_pkg::STAT_OUT_LSB+1] = out_level[1];
    status_rd[csc_pkg::STAT_OUT_LSB]   = out_level[0];
  end

  // Events still set their channel event flags in Idle; with idle stop set their interrupt flags are not set, so no request is raised
  assign irq_set = (idle_mode && idle_stop) ? 3'h0 : evt_pulse;

  csc_irq u_irq (
    .clk      (clk),
    .rst      (rst),
    .set      (irq_set),
    .wr_flags (wr_go && avs_address == csc_pkg::ADDR_IRQ_FLAGS),
    .wr_mask  (wr_go && avs_address == csc_pkg::ADDR_IRQ_MASK && avs_byteenable[0]),
    .wdata    (avs_byteenable[0] ? avs_writedata[2:0] : 3'h0),
    .flags    (irq_flags),
    .mask     (irq_mask),
    .irq      (irq)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_go) begin
      case (avs_address)
        csc_pkg::ADDR_CTRL1:     avs_readdata <= {16'h0000, ctrl_rd[0]};
        csc_pkg::ADDR_CTRL2:     avs_readdata <= {16'h0000, ctrl_rd[1]};
        csc_pkg::ADDR_CTRL3:     avs_readdata <= {16'h0000, ctrl_rd[2]};
        csc_pkg::ADDR_STATUS:    avs_readdata <= {16'h0000, status_rd};
        csc_pkg::ADDR_IRQ_FLAGS: avs_readdata <= {29'h00000000, irq_flags};
        csc_pkg::ADDR_IRQ_MASK:  avs_readdata <= {29'h00000000, irq_mask};
        default:                 avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: sim/comparator_status_control_test.sv */
`timescale 1ns/100ps
`default_nettype none
module comparator_status_control_test;
  logic        clk = 0, rst = 1, avs_read = 0, avs_write = 0, idle_mode = 0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, irq;
  logic [2:0]  cmp_out_raw, pos_ref_sel, pin_a_hi = 3'h0;
  logic [5:0]  neg_chan_sel;
  logic [7:0]  neg_lv = 8'h1B;
  int          err_total = 0, check_count = 0, cyc = 0;
  always #5 clk = ~clk;
  csc_status_control csc_status_control_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .idle_mode(idle_mode), .cmp_out_raw(cmp_out_raw), .pos_ref_sel(pos_ref_sel),
    .neg_chan_sel(neg_chan_sel), .irq(irq));
  csc_cmp_model csc_cmp_model_inst (.ref_sel(pos_ref_sel), .chan_sel(neg_chan_sel),
    .pin_a_hi(pin_a_hi), .neg_lv(neg_lv), .cmp_out(cmp_out_raw));
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic t_reset;
    acc(0, csc_pkg::ADDR_STATUS, 16'h0000);
    chk(q, 32'h0);
    acc(1, 4'h9, 16'hFFFF);
    acc(0, 4'h9, 16'h0000);
    chk(q, 32'h0);
  endtask
  task automatic t_chan;
    for (int ch = 0; ch < 4; ch++) begin
      acc(1, csc_pkg::ADDR_CTRL2, 16'h0010 | 16'(ch));
      // Selections update at the completing edge; look one edge later
      @(posedge clk);
      chk(neg_chan_sel[3:2], 32'(ch));
      chk(pos_ref_sel[1], 1);
      repeat (6) @(posedge clk);
      acc(0, csc_pkg::ADDR_STATUS, 16'h0000);
      chk(q[1], 32'(2'h2 > neg_lv[2*ch+:2]));
      acc(0, csc_pkg::ADDR_CTRL2, 16'h0000);
      chk(q[4:0], 32'h10 | 32'(ch));
    end
  endtask
  task automatic t_mirror;
    pin_a_hi <= 3'h7;
    for (int g = 0; g < 3; g++) acc(1, 4'(g), 16'h0001);
    repeat (8) @(posedge clk);
    acc(0, csc_pkg::ADDR_STATUS, 16'h0000);
    // Comparator 2 keeps its level, so its flag stays cleared by the write
    chk(q, 32'h0507);
    for (int g = 0; g < 3; g++) acc(1, 4'(g), 16'h0001);
    acc(0, csc_pkg::ADDR_STATUS, 16'h0000);
    chk(q, 32'h0007);
    acc(1, csc_pkg::ADDR_STATUS, 16'hFFFF);
    acc(0, csc_pkg::ADDR_STATUS, 16'h0000);
    chk(q, 32'h8007);
  endtask
  task automatic t_irq;
    acc(1, csc_pkg::ADDR_IRQ_MASK, 16'h0007);
    repeat (3) @(posedge clk);
    chk(irq, 1);
    acc(1, csc_pkg::ADDR_IRQ_FLAGS, 16'h0007);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    idle_mode <= 1'b1;
    pin_a_hi <= 3'h6;
    repeat (8) @(posedge clk);
    chk(irq, 0);
    acc(0, csc_pkg::ADDR_STATUS, 16'h0000);
    chk(q[8], 1);
    acc(1, csc_pkg::ADDR_STATUS, 16'h0000);
    pin_a_hi <= 3'h7;
    repeat (8) @(posedge clk);
    chk(irq, 1);
    acc(1, csc_pkg::ADDR_IRQ_MASK, 16'h0000);
    repeat (3) @(posedge clk);
    chk(irq, 0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_chan;
    t_mirror;
    t_irq;
    end_of_test;
  end
endmodule
bind csc_status_control csc_monitor csc_monitor_inst (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pos_ref_sel(pos_ref_sel), .neg_chan_sel(neg_chan_sel),
  .irq(irq));
`default_nettype wire

/* File: sim/csc_cmp_model.sv */
`timescale 1ns/100ps
`default_nettype none
module csc_cmp_model (
  input  wire logic [2:0] ref_sel,
  input  wire logic [5:0] chan_sel,
  input  wire logic [2:0] pin_a_hi,
  input  wire logic [7:0] neg_lv,
  output logic      [2:0] cmp_out
);
  // Internal reference sits at level 2, pin A at 3 or 0
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      cmp_out[g] = (ref_sel[g] ? 2'h2 : {2{pin_a_hi[g]}}) > neg_lv[2*chan_sel[2*g+:2]+:2];
    end
  end
endmodule
`default_nettype wire

/* File: sim/csc_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module csc_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [2:0]  pos_ref_sel,
  input wire logic [5:0]  neg_chan_sel,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire rdone = avs_read && !avs_waitrequest;
  wire wdone = avs_write && !avs_waitrequest && avs_byteenable[0];
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop");
  a_wait_rest: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_ctrl_zero: assert property (rdone && avs_address < 4'h3 |-> avs_readdata[3:2] == 2'h0)
    else $error("control gap bits set");
  a_stat_zero: assert property (rdone && avs_address == csc_pkg::ADDR_STATUS |->
    avs_readdata[14:11] == 4'h0 && avs_readdata[7:3] == 5'h00) else $error("status gap bits set");
  a_unmapped_zero: assert property (rdone && avs_address > 4'h5 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ref_follow: assert property (wdone && avs_address == csc_pkg::ADDR_CTRL1 |=>
    pos_ref_sel[0] == $past(avs_writedata[4])) else $error("reference select wrong");
  a_chan_follow: assert property (wdone && avs_address == csc_pkg::ADDR_CTRL3 |=>
    neg_chan_sel[5:4] == $past(avs_writedata[1:0])) else $error("channel select wrong");
  a_sel_hold: assert property (!wdone |=> $stable({pos_ref_sel, neg_chan_sel}))
    else $error("selection changed without write");
  cover property (irq);
  cover property (wdone && avs_address == csc_pkg::ADDR_STATUS);
  cover property (rdone && avs_address == csc_pkg::ADDR_STATUS);
endmodule
`default_nettype wire
